// file: hdl/scs_status_params.svh
// Summary of operation
// R1 - Flag behaviour below applies only while the card mode select bit is 1.
// R2 - Transmit-empty flag is bit 7, resets to 1, held set while transmitter disabled.
// R3 - Transmit-empty flag sets when a byte moves from holding to shift register.
// R4 - Transmit-empty flag clears when software writes 0 after reading it as 1.
// R5 - Transmit-empty flag clears when the DMA writes the transmit holding register.
// R6 - Receive-full flag is bit 6, resets to 0, sets on clean reception.
// R7 - Receive-full flag clears when software writes 0 after reading it as 1.
// R8 - Receive-full flag clears when the DMA reads the receive holding register.
// R9 - Receive-full flag keeps its value when the receiver is disabled.
// R10 - Overrun flag is bit 5, resets to 0, sets on reception while receive-full.
// R11 - On overrun the old byte stays held and the new byte is dropped.
// R12 - While the overrun flag is 1 no further reception takes place.
// R13 - In clocked synchronous operation transmission halts while overrun is set.
// R14 - Overrun flag clears when software writes 0 after reading it as 1.
// R15 - Overrun flag keeps its value when the receiver is disabled.
// R16 - Error-signal flag is bit 4, resets to 0, sets on sampled low error signal.
// R17 - Error-signal flag clears when software writes 0 after reading it as 1.
// R18 - Software clearing a flag with its interrupt enabled reads it back afterwards.
// R19 - Writing 1 to any of the four flags leaves it unchanged.
// R20 - A written 0 clears only a flag read as 1 since it last became set.
`ifndef SCS_STATUS_PARAMS_SVH
`define SCS_STATUS_PARAMS_SVH

// Register offsets
`define SCS_OFS_MODE 4'h0
`define SCS_OFS_CTRL 4'h1
`define SCS_OFS_STATUS 4'h2
`define SCS_OFS_TX_HOLD 4'h3
`define SCS_OFS_RX_HOLD 4'h4

// Status field positions
`define SCS_TX_EMPTY_BIT 7
`define SCS_RX_FULL_BIT 6
`define SCS_OVERRUN_BIT 5
`define SCS_CARD_ERR_BIT 4

// Control and mode field positions
`define SCS_TX_ENABLE_BIT 5
`define SCS_RX_ENABLE_BIT 4
`define SCS_CARD_MODE_BIT 0
`define SCS_SYNC_MODE_BIT 7

// Reset values
`define SCS_MODE_RST 8'h00
`define SCS_CTRL_RST 8'h00
`define SCS_HOLD_RST 8'h00
`define SCS_TX_EMPTY_RST 1'b1
`define SCS_FLAG_RST 1'b0

`endif

// file: hdl/scs_status_pkg.sv
package scs_status_pkg;

    // Data byte of the serial unit
    typedef logic [7:0] scs_byte_t;

    // Register address on the plain port
    typedef logic [3:0] scs_addr_t;

    // Index of each flag cell in the flag vector
    typedef enum {
        SCS_FLAG_CARD_ERR,
        SCS_FLAG_OVERRUN,
        SCS_FLAG_RX_FULL,
        SCS_FLAG_TX_EMPTY
    } scs_flag_idx_t;

endpackage

// file: hdl/scs_pin_sync.sv
`timescale 1ns/1ps

module scs_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic pin_in,
    output logic level_out
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // Three-stage chain; first stage feeds only the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Level only moves once the last two stages agree
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_out <= RESET_LEVEL;
        end else if (stage2_reg == stage3_reg) begin
            level_out <= stage3_reg;
        end
    end

endmodule

// file: hdl/scs_flag_cell.sv
`timescale 1ns/1ps

module scs_flag_cell #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic set_in,
    input wire logic hw_clear_in,
    input wire logic read_in,
    input wire logic write_zero_in,
    output logic flag_out
);

    logic armed_reg;
    logic sw_clear;

    // Software clear needs a prior read of 1 since the flag rose
    assign sw_clear = write_zero_in & armed_reg; // [R20]

    // Flag: set wins over any clear in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_out <= RESET_VALUE;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (sw_clear || hw_clear_in) begin
            flag_out <= 1'b0;
        end
    end

    // Arm on a read of 1, disarm whenever the flag drops
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            armed_reg <= 1'b0;
        end else if (!set_in && (sw_clear || hw_clear_in)) begin
            armed_reg <= 1'b0;
        end else if (read_in && flag_out) begin
            armed_reg <= 1'b1; // [R20]
        end
    end

endmodule

// file: hdl/scs_status.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "scs_status_params.svh"

module scs_status
    import scs_status_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // DMA side
    input wire logic dma_tx_write_in,
    input wire logic [7:0] dma_tx_data_in,
    input wire logic dma_rx_read_in,
    output logic [7:0] dma_rx_data_out,
    output logic tx_data_request_out,
    output logic rx_data_request_out,
    // Transmit shifter side
    input wire logic tx_shift_load_in,
    output logic [7:0] tx_shift_data_out,
    output logic tx_shift_valid_out,
    output logic tx_halt_out,
    // Receive shifter side
    input wire logic rx_done_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_parity_ok_in,
    output logic rx_enable_out,
    // Card line and error-signal sample strobe
    input wire logic card_io_in,
    input wire logic err_sample_in
);

    // Software registers
    scs_byte_t mode_reg;
    scs_byte_t ctrl_reg;
    scs_byte_t tx_hold_reg;
    scs_byte_t rx_hold_reg;

    // Decoded control bits
    logic card_mode;
    logic sync_mode;
    logic tx_enable;
    logic rx_enable;

    // Flag vector, indexed by scs_flag_idx_t
    logic [3:0] flag_vec;
    logic [3:0] set_vec;
    logic [3:0] hw_clear_vec;
    logic [3:0] wzero_vec;
    logic [7:0] status_byte;

    // Bus decode
    logic status_read;
    logic status_write;
    logic tx_hold_write;
    logic rx_hold_read;

    // Datapath events
    logic tx_move;
    logic rx_accept;
    logic rx_clean;
    logic rx_overrun;
    logic card_io_level;
    logic card_error;

    // Decoded control and mode bits
    assign card_mode = mode_reg[`SCS_CARD_MODE_BIT];
    assign sync_mode = mode_reg[`SCS_SYNC_MODE_BIT];
    assign tx_enable = ctrl_reg[`SCS_TX_ENABLE_BIT];
    assign rx_enable = ctrl_reg[`SCS_RX_ENABLE_BIT];

    // Address decode of the plain register port
    assign status_read = rd_in && (addr_in == `SCS_OFS_STATUS);
    assign status_write = wr_in && (addr_in == `SCS_OFS_STATUS);
    assign tx_hold_write = wr_in && (addr_in == `SCS_OFS_TX_HOLD);
    assign rx_hold_read = rd_in && (addr_in == `SCS_OFS_RX_HOLD);

    // Mode register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_reg <= `SCS_MODE_RST;
        end else if (wr_in && (addr_in == `SCS_OFS_MODE)) begin
            mode_reg <= wdata_in;
        end
    end

    // Control register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_reg <= `SCS_CTRL_RST;
        end else if (wr_in && (addr_in == `SCS_OFS_CTRL)) begin
            ctrl_reg <= wdata_in;
        end
    end

    // Card line passes the three-stage synchroniser
    scs_pin_sync #(
        .RESET_LEVEL(1'b1)
    ) u_card_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .pin_in(card_io_in),
        .level_out(card_io_level)
    );

    // Error signal: low card line at the sample strobe while sending
    assign card_error = card_mode && tx_enable && err_sample_in && !card_io_level; // [R16]

    // Transmit move from holding to shift register
    assign tx_move = card_mode && tx_enable && tx_shift_load_in && !tx_halt_out
        && !flag_vec[SCS_FLAG_TX_EMPTY];

    // Halt transmission on overrun in clocked synchronous operation
    assign tx_halt_out = sync_mode && flag_vec[SCS_FLAG_OVERRUN]; // [R13]

    // Receiver runs only while enabled and no overrun pending
    assign rx_enable_out = rx_enable && !flag_vec[SCS_FLAG_OVERRUN]; // [R12]

    // Completed reception, sorted into clean store or overrun; a bad-parity byte while not full is neither
    assign rx_accept = card_mode && rx_done_in && rx_enable_out; // [R12]
    assign rx_clean = rx_accept && rx_parity_ok_in && !flag_vec[SCS_FLAG_RX_FULL]; // [R6]
    assign rx_overrun = rx_accept && flag_vec[SCS_FLAG_RX_FULL]; // [R10]

    // Transmit holding register, written by CPU or DMA
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_hold_reg <= `SCS_HOLD_RST;
        end else if (dma_tx_write_in) begin
            tx_hold_reg <= dma_tx_data_in;
        end else if (tx_hold_write) begin
            tx_hold_reg <= wdata_in;
        end
    end

    // Shift register load and its one-cycle valid
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_shift_data_out <= `SCS_HOLD_RST;
            tx_shift_valid_out <= 1'b0;
        end else begin
            tx_shift_valid_out <= tx_move;
            if (tx_move) begin
                tx_shift_data_out <= tx_hold_reg;
            end
        end
    end

    // Receive holding register keeps the old byte on overrun
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_hold_reg <= `SCS_HOLD_RST;
        end else if (rx_clean) begin
            rx_hold_reg <= rx_byte_in; // [R11]
        end
    end

    assign dma_rx_data_out = rx_hold_reg;

    // Data requests towards the DMA controller
    assign tx_data_request_out = card_mode && tx_enable && flag_vec[SCS_FLAG_TX_EMPTY];
    assign rx_data_request_out = card_mode && flag_vec[SCS_FLAG_RX_FULL];

    // Set events per flag; only active in card mode
    always_comb begin
        set_vec = 4'h0;
        // Transmit-empty held set while the transmitter is off
        set_vec[SCS_FLAG_TX_EMPTY] = card_mode && (!tx_enable || tx_move); // [R1] [R2] [R3]
        // Receive-full only on a clean store; clearing the enable bit does not clear it
        set_vec[SCS_FLAG_RX_FULL] = rx_clean; // [R6] [R9]
        // Overrun on a completed reception while still full
        set_vec[SCS_FLAG_OVERRUN] = rx_overrun; // [R10] [R15]
        // Error signal seen on the synchronised card line
        set_vec[SCS_FLAG_CARD_ERR] = card_error; // [R16]
    end

    // Hardware clears from DMA transfers
    always_comb begin
        hw_clear_vec = 4'h0;
        hw_clear_vec[SCS_FLAG_TX_EMPTY] = card_mode && dma_tx_write_in; // [R5]
        hw_clear_vec[SCS_FLAG_RX_FULL] = card_mode && dma_rx_read_in; // [R8]
    end

    // Software write of 0 per bit; a written 1 does nothing
    always_comb begin
        wzero_vec = 4'h0;
        wzero_vec[SCS_FLAG_TX_EMPTY] = card_mode && status_write
            && !wdata_in[`SCS_TX_EMPTY_BIT]; // [R4] [R19]
        wzero_vec[SCS_FLAG_RX_FULL] = card_mode && status_write
            && !wdata_in[`SCS_RX_FULL_BIT]; // [R7] [R19]
        wzero_vec[SCS_FLAG_OVERRUN] = card_mode && status_write
            && !wdata_in[`SCS_OVERRUN_BIT]; // [R14] [R19]
        wzero_vec[SCS_FLAG_CARD_ERR] = card_mode && status_write
            && !wdata_in[`SCS_CARD_ERR_BIT]; // [R17] [R19]
    end

    // Status byte as software sees it; low nibble reads 0
    always_comb begin
        status_byte = 8'h00;
        status_byte[`SCS_TX_EMPTY_BIT] = flag_vec[SCS_FLAG_TX_EMPTY]; // [R2]
        status_byte[`SCS_RX_FULL_BIT] = flag_vec[SCS_FLAG_RX_FULL]; // [R6]
        status_byte[`SCS_OVERRUN_BIT] = flag_vec[SCS_FLAG_OVERRUN]; // [R10]
        status_byte[`SCS_CARD_ERR_BIT] = flag_vec[SCS_FLAG_CARD_ERR]; // [R16]
    end

    // One flag cell per status flag
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            scs_flag_cell #(
                .RESET_VALUE((gi == SCS_FLAG_TX_EMPTY) ? `SCS_TX_EMPTY_RST : `SCS_FLAG_RST)
            ) u_cell (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .set_in(set_vec[gi]),
                .hw_clear_in(hw_clear_vec[gi]),
                .read_in(status_read),
                .write_zero_in(wzero_vec[gi]),
                .flag_out(flag_vec[gi])
            );
        end
    endgenerate

    // Read data one cycle after the read strobe; zero otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                `SCS_OFS_MODE: begin
                    rdata_out <= mode_reg;
                end
                `SCS_OFS_CTRL: begin
                    rdata_out <= ctrl_reg;
                end
                `SCS_OFS_STATUS: begin
                    rdata_out <= status_byte;
                end
                `SCS_OFS_TX_HOLD: begin
                    rdata_out <= tx_hold_reg;
                end
                `SCS_OFS_RX_HOLD: begin
                    rdata_out <= rx_hold_reg;
                end
                default: begin
                    rdata_out <= 8'h00;
                end
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule

// file: bench/scs_status_checker.sv
`timescale 1ns/1ps

module scs_status_checker (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic dma_tx_write_in,
    input wire logic dma_rx_read_in,
    input wire logic [7:0] dma_rx_data_out,
    input wire logic tx_data_request_out,
    input wire logic rx_data_request_out,
    input wire logic tx_shift_load_in,
    input wire logic tx_shift_valid_out,
    input wire logic tx_halt_out,
    input wire logic rx_done_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_parity_ok_in,
    input wire logic rx_enable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Port, transmit and receive relations
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data not zero outside read answer");
    a_valid_cause: assert property (tx_shift_valid_out |-> $past(tx_shift_load_in))
        else $error("shift valid without load");
    a_valid_single: assert property (tx_shift_valid_out |=> !tx_shift_valid_out)
        else $error("shift valid longer than one cycle");
    a_tx_empty_set: assert property (tx_shift_valid_out && !$past(wr_in) |-> tx_data_request_out)
        else $error("empty flag not set after move");
    a_dma_tx_clear: assert property (dma_tx_write_in && tx_data_request_out && !tx_shift_load_in
        |=> !tx_data_request_out)
        else $error("dma write did not clear empty flag");
    a_dma_rx_clear: assert property (dma_rx_read_in && rx_data_request_out && !rx_done_in
        |=> !rx_data_request_out)
        else $error("dma read did not clear full flag");
    a_rx_full_set: assert property ($rose(rx_data_request_out) && !$past(wr_in)
        |-> $past(rx_done_in && rx_parity_ok_in) && dma_rx_data_out == $past(rx_byte_in))
        else $error("full flag rose without clean reception");
    a_hold_kept: assert property (rx_data_request_out |=> $stable(dma_rx_data_out))
        else $error("holding byte replaced while full");
    a_ovr_blocks_rx: assert property (rx_data_request_out && rx_done_in && rx_enable_out
        |=> !rx_enable_out)
        else $error("reception still enabled after overrun");
    a_halt_blocks_tx: assert property (tx_halt_out && tx_shift_load_in |=> !tx_shift_valid_out)
        else $error("byte moved while halted");

    // Main scenarios
    c_move: cover property (tx_shift_valid_out);
    c_overrun: cover property (rx_data_request_out && rx_done_in);
    c_halt: cover property (tx_halt_out && tx_shift_load_in);
endmodule

bind scs_status scs_status_checker scs_status_checker_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .dma_tx_write_in(dma_tx_write_in), .dma_rx_read_in(dma_rx_read_in),
    .dma_rx_data_out(dma_rx_data_out), .tx_data_request_out(tx_data_request_out),
    .rx_data_request_out(rx_data_request_out), .tx_shift_load_in(tx_shift_load_in),
    .tx_shift_valid_out(tx_shift_valid_out), .tx_halt_out(tx_halt_out), .rx_done_in(rx_done_in),
    .rx_byte_in(rx_byte_in), .rx_parity_ok_in(rx_parity_ok_in), .rx_enable_out(rx_enable_out)
);

// file: bench/scs_card_model.sv
`timescale 1ns/1ps

module scs_card_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic signal_error_in,
    output logic card_io_out
);
    // Card pulls the line low to flag a bad character, else the pull-up holds it high
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            card_io_out <= 1'b1;
        end else begin
            card_io_out <= !signal_error_in;
        end
    end
endmodule

// file: bench/smartcard_serial_status_flags_test.sv
`timescale 1ns/1ps

module smartcard_serial_status_flags_test;
    localparam logic [4:0] DTX = 5'h01;
    localparam logic [4:0] DRX = 5'h02;
    localparam logic [4:0] LOAD = 5'h04;
    localparam logic [4:0] RXD = 5'h08;
    localparam logic [4:0] ERR = 5'h10;
    logic clk_in, nrst_in, wr_in, rd_in, ok, card_err, card_io, tx_req, rx_req, valid, halt, rx_en;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, dat, dma_rx, tx_sh;
    logic [4:0] ev;
    int bad_count = 0;
    int n_compared = 0;

    scs_card_model scs_card_model_i (.clk_in(clk_in), .nrst_in(nrst_in),
        .signal_error_in(card_err), .card_io_out(card_io));

    scs_status scs_status_i (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .dma_tx_write_in(ev[0]), .dma_tx_data_in(dat), .dma_rx_read_in(ev[1]),
        .dma_rx_data_out(dma_rx), .tx_data_request_out(tx_req), .rx_data_request_out(rx_req),
        .tx_shift_load_in(ev[2]), .tx_shift_data_out(tx_sh), .tx_shift_valid_out(valid),
        .tx_halt_out(halt), .rx_done_in(ev[3]), .rx_byte_in(dat), .rx_parity_ok_in(ok),
        .rx_enable_out(rx_en), .card_io_in(card_io), .err_sample_in(ev[4]));

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // Read strobe one cycle, answer sampled in the following cycle
    task rs(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    task pulse(input logic [4:0] e, input logic [7:0] b, input logic good);
        @(posedge clk_in);
        ev <= e;
        dat <= b;
        ok <= good;
        @(posedge clk_in);
        ev <= 5'h00;
        #1;
    endtask

    task wrap_up;
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Free-running clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Reset, then the scenarios
    initial begin
        {nrst_in, wr_in, rd_in, ok, card_err, addr, wdata, dat, ev} = '0;
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        rs(2, 8'h80);
        pulse(RXD, 8'h5a, 1'b1);
        rs(2, 8'h80);
        wr(0, 8'h01);
        rs(2, 8'h80);
        wr(2, 8'h00);
        rs(2, 8'h80);
        wr(1, 8'h30);
        rs(2, 8'h80);
        wr(2, 8'hff);
        rs(2, 8'h80);
        wr(2, 8'h7f);
        rs(2, 8'h00);
        pulse(DTX, 8'ha5, 1'b1);
        pulse(LOAD, 8'h00, 1'b1);
        chk(tx_sh, 8'ha5);
        chk({7'h00, valid}, 8'h01);
        wr(2, 8'h00);
        rs(2, 8'h80);
        pulse(DTX, 8'h5a, 1'b1);
        rs(2, 8'h00);
        pulse(RXD, 8'h3c, 1'b1);
        rs(2, 8'h40);
        rs(4, 8'h3c);
        pulse(RXD, 8'hc3, 1'b1);
        rs(2, 8'h60);
        rs(4, 8'h3c);
        chk({7'h00, rx_en}, 8'h00);
        wr(1, 8'h20);
        rs(2, 8'h60);
        wr(1, 8'h30);
        wr(2, 8'hdf);
        rs(2, 8'h40);
        pulse(DRX, 8'h00, 1'b1);
        chk(dma_rx, 8'h3c);
        rs(2, 8'h00);
        pulse(RXD, 8'h77, 1'b1);
        rs(2, 8'h40);
        wr(2, 8'hbf);
        rs(2, 8'h00);
        pulse(RXD, 8'h11, 1'b0);
        rs(2, 8'h00);
        card_err <= 1'b1;
        repeat (6) @(posedge clk_in);
        pulse(ERR, 8'h00, 1'b1);
        card_err <= 1'b0;
        rs(2, 8'h10);
        wr(2, 8'hef);
        rs(2, 8'h00);
        wr(0, 8'h81);
        pulse(RXD, 8'h22, 1'b1);
        pulse(RXD, 8'h33, 1'b1);
        chk({7'h00, halt}, 8'h01);
        pulse(LOAD, 8'h00, 1'b1);
        chk({7'h00, valid}, 8'h00);
        wrap_up();
    end
endmodule
